// *** core/bole_pkg.sv ***
package bole_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam int unsigned BOLE_AXI_AW = 16;
    localparam logic [15:0] BOLE_OFF_CMD = 16'h0000;
    localparam logic [15:0] BOLE_OFF_ADDR = 16'h0004;
    localparam logic [15:0] BOLE_OFF_STATUS = 16'h0008;
    localparam logic [15:0] BOLE_OFF_FLAGS = 16'h000c;
    localparam logic [15:0] BOLE_OFF_GPR = 16'h0100;
    localparam logic [15:0] BOLE_OFF_IO = 16'h0200;
    localparam logic [15:0] BOLE_OFF_DMEM = 16'h1000;
    localparam logic [15:0] BOLE_GPR_SPAN = 16'h0080;
    localparam logic [15:0] BOLE_IO_SPAN = 16'h0080;

    // ****************************************
    // Sizes and reset values
    // ****************************************
    localparam int unsigned BOLE_DMEM_DEPTH = 256;
    localparam logic [7:0] BOLE_FLAGS_RST = 8'h00;
    localparam logic [15:0] BOLE_ADDR_RST = 16'h0000;

    // ****************************************
    // Flag register bit positions
    // ****************************************
    localparam int unsigned BOLE_FLG_C = 0;
    localparam int unsigned BOLE_FLG_Z = 1;
    localparam int unsigned BOLE_FLG_N = 2;
    localparam int unsigned BOLE_FLG_V = 3;
    localparam int unsigned BOLE_FLG_S = 4;
    localparam int unsigned BOLE_FLG_H = 5;
    localparam int unsigned BOLE_FLG_T = 6;
    localparam int unsigned BOLE_FLG_I = 7;

    // ****************************************
    // Pointer pairs (low register index)
    // ****************************************
    localparam logic [4:0] BOLE_PTR_X_LO = 5'h1a;
    localparam logic [4:0] BOLE_PTR_Y_LO = 5'h1c;
    localparam logic [4:0] BOLE_PTR_Z_LO = 5'h1e;

    // ****************************************
    // Cycle counts and bus answers
    // ****************************************
    localparam logic [1:0] BOLE_CYC_ONE = 2'h1;
    localparam logic [1:0] BOLE_CYC_TWO = 2'h2;
    localparam logic [1:0] BOLE_RESP_OKAY = 2'h0;
    localparam logic [1:0] BOLE_RESP_SLVERR = 2'h2;
    localparam logic [1:0] BOLE_RESP_DECERR = 2'h3;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [5:0] {
        BOLE_OP_NOP = 6'h00,
        BOLE_OP_SET_IO_BIT = 6'h01,
        BOLE_OP_CLEAR_IO_BIT = 6'h02,
        BOLE_OP_LOGICAL_SHIFT_LEFT = 6'h03,
        BOLE_OP_LOGICAL_SHIFT_RIGHT = 6'h04,
        BOLE_OP_ROTATE_LEFT_CARRY = 6'h05,
        BOLE_OP_ROTATE_RIGHT_CARRY = 6'h06,
        BOLE_OP_ARITH_SHIFT_RIGHT = 6'h07,
        BOLE_OP_SWAP = 6'h08,
        BOLE_OP_FLAG_SET = 6'h09,
        BOLE_OP_FLAG_CLEAR = 6'h0a,
        BOLE_OP_STORE_TO_TRANSFER_BIT = 6'h0b,
        BOLE_OP_LOAD_FROM_TRANSFER_BIT = 6'h0c,
        BOLE_OP_INDIRECT_LOAD = 6'h0d,
        BOLE_OP_DIRECT_LOAD = 6'h0e
    } bole_op_t;

    typedef enum logic [1:0] {
        BOLE_PTR_X = 2'h0,
        BOLE_PTR_Y = 2'h1,
        BOLE_PTR_Z = 2'h2,
        BOLE_PTR_NONE = 2'h3
    } bole_ptr_t;

    typedef enum logic [1:0] {
        BOLE_MODE_PLAIN = 2'h0,
        BOLE_MODE_POSTINC = 2'h1,
        BOLE_MODE_PREDEC = 2'h2,
        BOLE_MODE_DISP = 2'h3
    } bole_mode_t;

    typedef enum logic [1:0] {
        BOLE_ST_IDLE = 2'h0,
        BOLE_ST_EXEC = 2'h1,
        BOLE_ST_FINISH = 2'h2
    } bole_state_t;

    // Command word layout, low bits first: op, reg, bit, ptr, disp, mode
    typedef struct packed {
        bole_mode_t mode;
        logic [5:0] disp;
        bole_ptr_t ptr;
        logic [2:0] bsel;
        logic [4:0] rsel;
        logic [5:0] op;
    } bole_cmd_t;

    typedef struct packed {
        logic [7:0] res;
        logic [7:0] flags;
    } bole_alu_t;

endpackage : bole_pkg

// *** core/bole_core.sv ***
// How it works
// - Set-I/O-bit forces one bit of an I/O register high, flags kept, two cycles.
// - Clear-I/O-bit forces one bit of an I/O register low, flags kept, two cycles.
// - Shift left: zero into bit 0, Z C N V updated, one cycle.
// - Shift right: zero into bit 7, Z C N V updated, one cycle.
// - Arithmetic shift right keeps bit 7, Z C N V updated, one cycle.
// - Nibble swap exchanges the two halves, flags untouched, one cycle.
// - Store-to-transfer copies a register bit into T only, one cycle.
// - Load-from-transfer writes T into a register bit, flags kept, one cycle.
// - Flag set or clear changes only the chosen flag, one cycle.
// - Overflow flag set and clear are one-cycle and touch only V.
// - Sign flag set and clear are one-cycle and touch only S.
// - Post-increment load reads at the pointer, then bumps it, two cycles.
// - Pre-decrement load lowers the pointer, then reads there, two cycles.
// - Displaced load via Y or Z reads pointer plus q, pointer kept.
// - Direct load reads the immediate address, flags kept, two cycles.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module bole_core
    import bole_pkg::*;
#(
    parameter int unsigned DMEM_DEPTH = BOLE_DMEM_DEPTH
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [BOLE_AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [BOLE_AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic exec_busy,
    output logic [7:0] flag_register
);

    localparam int unsigned DMEM_AW = $clog2(DMEM_DEPTH);
    localparam logic [15:0] DMEM_SPAN = 16'((DMEM_DEPTH * 4) & 16'hffff);

    // ****************************************
    // Storage
    // ****************************************
    logic [7:0] gpr_r [32];
    logic [7:0] io_r [32];
    logic [7:0] dmem_r [DMEM_DEPTH];
    logic [7:0] flags_r;
    logic [15:0] addr_r;
    logic [15:0] ea_r;
    bole_cmd_t cmd_r;
    bole_state_t state_r;
    logic illegal_r;
    logic [1:0] last_cyc_r;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic bole_alu_t shift_alu(input logic [5:0] op, input logic [7:0] d,
                                            input logic [7:0] f);
        bole_alu_t a;
        logic c;
        a.flags = f;
        a.res = d;
        c = d[0];
        case (op)
            BOLE_OP_LOGICAL_SHIFT_LEFT: begin
                a.res = {d[6:0], 1'b0};
                c = d[7];
            end
            BOLE_OP_LOGICAL_SHIFT_RIGHT: a.res = {1'b0, d[7:1]};
            BOLE_OP_ROTATE_LEFT_CARRY: begin
                a.res = {d[6:0], f[BOLE_FLG_C]};
                c = d[7];
            end
            BOLE_OP_ROTATE_RIGHT_CARRY: a.res = {f[BOLE_FLG_C], d[7:1]};
            BOLE_OP_ARITH_SHIFT_RIGHT: a.res = {d[7], d[7:1]};
            default: a.res = d;
        endcase
        a.flags[BOLE_FLG_C] = c;
        a.flags[BOLE_FLG_Z] = (a.res == 8'h00);
        a.flags[BOLE_FLG_N] = a.res[7];
        a.flags[BOLE_FLG_V] = a.res[7] ^ c;
        return a;
    endfunction : shift_alu

    function automatic logic [4:0] ptr_lo(input bole_ptr_t p);
        case (p)
            BOLE_PTR_Y: ptr_lo = BOLE_PTR_Y_LO;
            BOLE_PTR_Z: ptr_lo = BOLE_PTR_Z_LO;
            default: ptr_lo = BOLE_PTR_X_LO;
        endcase
    endfunction : ptr_lo

    function automatic logic in_win(input logic [15:0] a, input logic [15:0] base,
                                    input logic [15:0] span);
        in_win = (a >= base) && (a < base + span);
    endfunction : in_win

    // ****************************************
    // Execution datapath
    // ****************************************
    logic [4:0] pa;
    logic [15:0] ptr_val;
    logic [15:0] ea_nxt;
    bole_alu_t alu;
    logic gwe;
    logic [4:0] gwa;
    logic [7:0] gwd;
    logic pwe;
    logic [15:0] pwd;
    logic iwe;
    logic [7:0] iwd;
    logic [7:0] flags_nxt;
    logic [7:0] rd_val;

    assign pa = ptr_lo(cmd_r.ptr);
    assign ptr_val = {gpr_r[5'(pa + 5'h01)], gpr_r[pa]};
    assign rd_val = gpr_r[cmd_r.rsel];
    assign alu = shift_alu(cmd_r.op, rd_val, flags_r);

    always_comb begin
        gwe = 1'b0;
        gwa = cmd_r.rsel;
        gwd = 8'h00;
        pwe = 1'b0;
        pwd = ptr_val;
        iwe = 1'b0;
        iwd = io_r[addr_r[4:0]];
        flags_nxt = flags_r;
        ea_nxt = ea_r;
        if (state_r == BOLE_ST_EXEC) begin
            case (cmd_r.op)
                BOLE_OP_LOGICAL_SHIFT_LEFT, BOLE_OP_LOGICAL_SHIFT_RIGHT,
                BOLE_OP_ROTATE_LEFT_CARRY, BOLE_OP_ROTATE_RIGHT_CARRY,
                BOLE_OP_ARITH_SHIFT_RIGHT: begin
                    gwe = 1'b1;
                    gwd = alu.res;
                    flags_nxt = alu.flags;
                end
                BOLE_OP_SWAP: begin
                    gwe = 1'b1;
                    gwd = {rd_val[3:0], rd_val[7:4]};
                end
                BOLE_OP_FLAG_SET: flags_nxt[cmd_r.bsel] = 1'b1;
                BOLE_OP_FLAG_CLEAR: flags_nxt[cmd_r.bsel] = 1'b0;
                BOLE_OP_STORE_TO_TRANSFER_BIT: begin
                    flags_nxt[BOLE_FLG_T] = rd_val[cmd_r.bsel];
                end
                BOLE_OP_LOAD_FROM_TRANSFER_BIT: begin
                    gwe = 1'b1;
                    gwd = rd_val;
                    gwd[cmd_r.bsel] = flags_r[BOLE_FLG_T];
                end
                BOLE_OP_INDIRECT_LOAD: begin
                    case (cmd_r.mode)
                        BOLE_MODE_PREDEC: begin
                            ea_nxt = ptr_val - 16'h0001;
                            pwe = 1'b1;
                            pwd = ea_nxt;
                        end
                        BOLE_MODE_DISP: begin
                            // X has no displaced form; q is ignored there
                            ea_nxt = (cmd_r.ptr == BOLE_PTR_X) ? ptr_val
                                : ptr_val + {10'h000, cmd_r.disp};
                        end
                        default: ea_nxt = ptr_val;
                    endcase
                end
                BOLE_OP_DIRECT_LOAD: ea_nxt = addr_r;
                default: ea_nxt = ea_r;
            endcase
        end else if (state_r == BOLE_ST_FINISH) begin
            case (cmd_r.op)
                BOLE_OP_SET_IO_BIT: begin
                    iwe = 1'b1;
                    iwd[cmd_r.bsel] = 1'b1;
                end
                BOLE_OP_CLEAR_IO_BIT: begin
                    iwe = 1'b1;
                    iwd[cmd_r.bsel] = 1'b0;
                end
                BOLE_OP_INDIRECT_LOAD, BOLE_OP_DIRECT_LOAD: begin
                    gwe = 1'b1;
                    gwd = dmem_r[ea_r[DMEM_AW-1:0]];
                    if (cmd_r.op == BOLE_OP_INDIRECT_LOAD && cmd_r.mode == BOLE_MODE_POSTINC) begin
                        pwe = 1'b1;
                        pwd = ea_r + 16'h0001;
                    end
                end
                default: gwe = 1'b0;
            endcase
        end
    end

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    logic aw_full_r;
    logic w_full_r;
    logic [15:0] wa_r;
    logic [31:0] wd_r;
    logic [3:0] ws_r;
    logic wr_go;
    logic idle;
    logic launch;
    logic bus_gpr_we;
    logic bus_io_we;
    logic bus_dm_we;
    logic wr_hit;
    logic bus_ok;

    assign idle = (state_r == BOLE_ST_IDLE);
    assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
    assign s_axi_wready = !w_full_r && !s_axi_bvalid;
    assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid;
    assign bus_ok = wr_go && ws_r[0] && idle;
    assign launch = bus_ok && wa_r == BOLE_OFF_CMD;
    assign bus_gpr_we = bus_ok && in_win(wa_r, BOLE_OFF_GPR, BOLE_GPR_SPAN);
    assign bus_io_we = bus_ok && in_win(wa_r, BOLE_OFF_IO, BOLE_IO_SPAN);
    assign bus_dm_we = bus_ok && in_win(wa_r, BOLE_OFF_DMEM, DMEM_SPAN);
    // Control words are the four lowest aligned offsets
    assign wr_hit = wa_r <= BOLE_OFF_FLAGS || in_win(wa_r, BOLE_OFF_GPR, BOLE_GPR_SPAN)
        || in_win(wa_r, BOLE_OFF_IO, BOLE_IO_SPAN) || in_win(wa_r, BOLE_OFF_DMEM, DMEM_SPAN);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            wa_r <= 16'h0000;
            wd_r <= 32'h0000_0000;
            ws_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= BOLE_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_r <= 1'b1;
                wa_r <= {s_axi_awaddr[15:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_r <= 1'b1;
                wd_r <= s_axi_wdata;
                ws_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (!wr_hit) begin
                    s_axi_bresp <= BOLE_RESP_DECERR;
                end else if (!idle && wa_r != BOLE_OFF_STATUS) begin
                    s_axi_bresp <= BOLE_RESP_SLVERR;
                end else begin
                    s_axi_bresp <= BOLE_RESP_OKAY;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= BOLE_ST_IDLE;
            cmd_r <= '0;
            ea_r <= 16'h0000;
            illegal_r <= 1'b0;
            last_cyc_r <= 2'h0;
        end else begin
            ea_r <= ea_nxt;
            case (state_r)
                BOLE_ST_IDLE: begin
                    if (launch) begin
                        cmd_r <= bole_cmd_t'(wd_r[23:0]);
                        illegal_r <= 1'b0;
                        state_r <= BOLE_ST_EXEC;
                    end
                end
                BOLE_ST_EXEC: begin
                    illegal_r <= (cmd_r.op > BOLE_OP_DIRECT_LOAD);
                    if (cmd_r.op inside {BOLE_OP_SET_IO_BIT, BOLE_OP_CLEAR_IO_BIT,
                        BOLE_OP_INDIRECT_LOAD, BOLE_OP_DIRECT_LOAD}) begin
                        state_r <= BOLE_ST_FINISH;
                    end else begin
                        last_cyc_r <= BOLE_CYC_ONE;
                        state_r <= BOLE_ST_IDLE;
                    end
                end
                BOLE_ST_FINISH: begin
                    last_cyc_r <= BOLE_CYC_TWO;
                    state_r <= BOLE_ST_IDLE;
                end
                default: state_r <= BOLE_ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // Architectural state writes
    // ****************************************
    always_ff @(posedge aclk) begin
        if (pwe) begin
            gpr_r[pa] <= pwd[7:0];
            gpr_r[5'(pa + 5'h01)] <= pwd[15:8];
        end
        if (gwe) begin
            gpr_r[gwa] <= gwd;
        end
        if (bus_gpr_we) begin
            gpr_r[wa_r[6:2]] <= wd_r[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (iwe) begin
            io_r[addr_r[4:0]] <= iwd;
        end
        if (bus_io_we) begin
            io_r[wa_r[6:2]] <= wd_r[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (bus_dm_we) begin
            dmem_r[DMEM_AW'(wa_r[15:2])] <= wd_r[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_r <= BOLE_FLAGS_RST;
            addr_r <= BOLE_ADDR_RST;
        end else begin
            flags_r <= flags_nxt;
            if (bus_ok && wa_r == BOLE_OFF_FLAGS) begin
                flags_r <= wd_r[7:0];
            end
            if (wr_go && idle && wa_r == BOLE_OFF_ADDR) begin
                if (ws_r[0]) begin
                    addr_r[7:0] <= wd_r[7:0];
                end
                if (ws_r[1]) begin
                    addr_r[15:8] <= wd_r[15:8];
                end
            end
        end
    end

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    logic [15:0] ra;
    logic [31:0] rd_mux;
    logic rd_hit;

    assign ra = {s_axi_araddr[15:2], 2'b00};
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        if (ra == BOLE_OFF_CMD) begin
            rd_mux = {8'h00, cmd_r};
        end else if (ra == BOLE_OFF_ADDR) begin
            rd_mux = {16'h0000, addr_r};
        end else if (ra == BOLE_OFF_STATUS) begin
            rd_mux = {22'h000000, last_cyc_r, 6'h00, illegal_r, !idle};
        end else if (ra == BOLE_OFF_FLAGS) begin
            rd_mux = {24'h000000, flags_r};
        end else if (in_win(ra, BOLE_OFF_GPR, BOLE_GPR_SPAN)) begin
            rd_mux = {24'h000000, gpr_r[ra[6:2]]};
        end else if (in_win(ra, BOLE_OFF_IO, BOLE_IO_SPAN)) begin
            rd_mux = {24'h000000, io_r[ra[6:2]]};
        end else if (in_win(ra, BOLE_OFF_DMEM, DMEM_SPAN)) begin
            rd_mux = {24'h000000, dmem_r[DMEM_AW'(ra[15:2])]};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= BOLE_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? BOLE_RESP_OKAY : BOLE_RESP_DECERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign exec_busy = !idle;
    assign flag_register = flags_r;

endmodule : bole_core

`default_nettype wire

// *** test/bole_core_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Port checks
// ****************************************
module bole_core_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic exec_busy,
    input wire logic [7:0] flag_register
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    AST_BUSY_LEN: assert property ($rose(exec_busy) |-> ##[1:2] !exec_busy)
        else $error("busy too long");
    AST_BUSY_GO: assert property ($rose(exec_busy) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("busy without command");
    AST_FLAG_SRC: assert property (flag_register != $past(flag_register)
        |-> $past(exec_busy) || s_axi_bvalid)
        else $error("stray flag change");
    AST_FLAG_ONE: assert property ($past(exec_busy) && !s_axi_bvalid
        && flag_register[7:4] != $past(flag_register[7:4])
        |-> $onehot(flag_register ^ $past(flag_register)))
        else $error("several flags changed");
    AST_B_ANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write response late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_R_TOP: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits set");
endmodule : bole_core_sva
`default_nettype wire

// *** test/bole_core_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module bole_core_tb
    import bole_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] s_axi_awaddr = 16'h0000;
    logic s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic [15:0] s_axi_araddr = 16'h0000;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, exec_busy;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rdv;
    logic [7:0] flag_register;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    always #5 aclk = ~aclk;
    bole_core bole_core_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .exec_busy, .flag_register);
    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        logic ta, tw, tb;
        tb = 1'b0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!tb) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [15:0] a);
        logic tr, td;
        td = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!td) begin
            @(negedge aclk);
            tr = s_axi_arvalid && s_axi_arready;
            td = s_axi_rvalid;
            rdv = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            if (tr) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    task automatic cr(input logic [15:0] a, input logic [7:0] e);
        rd(a);
        chk(rdv, {24'h0, e});
    endtask : cr
    function automatic logic [15:0] ad(input logic [15:0] base, input logic [7:0] i);
        return base + {6'h00, i, 2'b00};
    endfunction : ad
    function automatic logic [31:0] mk(input logic [5:0] op, input logic [4:0] r,
            input logic [2:0] b = 3'h0, input logic [1:0] p = 2'h0, input logic [5:0] q = 6'h00,
            input logic [1:0] m = 2'h0);
        return {8'h00, bole_cmd_t'({m, q, p, b, r, op})};
    endfunction : mk
    function automatic logic [15:0] ga(input logic [7:0] i);
        return ad(BOLE_OFF_GPR, i);
    endfunction : ga
    task automatic run(input logic [31:0] c, input logic [1:0] n);
        wr(BOLE_OFF_CMD, c);
        rdv = 32'h1;
        for (int k = 0; k < 20 && rdv[0]; k++) rd(BOLE_OFF_STATUS);
        chk(rdv, {22'h0, n, 8'h00});
    endtask : run
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            errors++;
            end_sim();
        end
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        logic [7:0] v, f, e, ef;
        logic [4:0] r;
        logic [2:0] b;
        void'($urandom(32'h534b220d));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        cr(BOLE_OFF_FLAGS, 8'h00);
        cr(16'h0800, 8'h00);
        chk({30'h0, rsp}, {30'h0, BOLE_RESP_DECERR});
        wr(ad(BOLE_OFF_GPR, 8'h01), 32'h5a);
        wr(ad(BOLE_OFF_GPR, 8'h01), 32'ha5, 4'he);
        cr(ad(BOLE_OFF_GPR, 8'h01), 8'h5a);
        $display("bus tests done");
        for (int p = 0; p < 2; p++) begin
            for (int op = 3; op < 9; op++) begin
                v = (p == 1) ? 8'($urandom) : 8'h80;
                f = 8'($urandom);
                r = 5'($urandom);
                wr(ga(8'(r)), {24'h0, v});
                wr(BOLE_OFF_FLAGS, {24'h0, f});
                run(mk(6'(op), r), 2'h1);
                case (op)
                    3: e = {v[6:0], 1'b0};
                    4: e = {1'b0, v[7:1]};
                    5: e = {v[6:0], f[0]};
                    6: e = {f[0], v[7:1]};
                    7: e = {v[7], v[7:1]};
                    default: e = {v[3:0], v[7:4]};
                endcase
                ef = f;
                if (op != 8) begin
                    ef[0] = (op == 3 || op == 5) ? v[7] : v[0];
                    ef[1] = (e == 8'h00);
                    ef[2] = e[7];
                    ef[3] = e[7] ^ ef[0];
                end
                cr(ga(8'(r)), e);
                cr(BOLE_OFF_FLAGS, ef);
            end
        end
        $display("shift tests done");
        for (int s = 0; s < 16; s++) begin
            f = 8'($urandom);
            wr(BOLE_OFF_FLAGS, {24'h0, f});
            run(mk((s < 8) ? 6'h09 : 6'h0a, 5'h00, 3'(s)), 2'h1);
            ef = f;
            ef[s % 8] = (s < 8);
            cr(BOLE_OFF_FLAGS, ef);
        end
        v = 8'($urandom);
        b = 3'($urandom);
        v[b + 3'h1] = ~v[b];
        wr(ga(8'h03), {24'h0, v});
        run(mk(6'h0b, 5'h03, b), 2'h1);
        ef[BOLE_FLG_T] = v[b];
        cr(BOLE_OFF_FLAGS, ef);
        run(mk(6'h0c, 5'h03, b + 3'h1), 2'h1);
        e = v;
        e[b + 3'h1] = v[b];
        cr(ga(8'h03), e);
        cr(BOLE_OFF_FLAGS, ef);
        $display("flag tests done");
        r = 5'($urandom);
        v = 8'($urandom);
        v[b] = 1'b0;
        wr(ad(BOLE_OFF_IO, 8'(r)), {24'h0, v});
        wr(BOLE_OFF_ADDR, {27'h0, r});
        run(mk(6'h01, 5'h00, b), 2'h2);
        e = v;
        e[b] = 1'b1;
        cr(ad(BOLE_OFF_IO, 8'(r)), e);
        run(mk(6'h02, 5'h00, b), 2'h2);
        cr(ad(BOLE_OFF_IO, 8'(r)), v);
        cr(BOLE_OFF_FLAGS, ef);
        $display("io bit tests done");
        wr(ad(BOLE_OFF_DMEM, 8'hff), {24'h0, v});
        wr(ga(8'd26), 32'hff);
        wr(ga(8'd27), 32'h00);
        run(mk(6'h0d, 5'h05, 3'h0, 2'h0, 6'h00, 2'h1), 2'h2);
        cr(ga(8'h05), v);
        cr(ga(8'd26), 8'h00);
        cr(ga(8'd27), 8'h01);
        run(mk(6'h0d, 5'h06, 3'h0, 2'h0, 6'h00, 2'h2), 2'h2);
        cr(ga(8'h06), v);
        cr(ga(8'd26), 8'hff);
        cr(ga(8'd27), 8'h00);
        e = 8'($urandom);
        wr(ad(BOLE_OFF_DMEM, 8'h15), {24'h0, e});
        wr(ga(8'd28), 32'h10);
        wr(ga(8'd29), 32'h00);
        run(mk(6'h0d, 5'h07, 3'h0, 2'h1, 6'h05, 2'h3), 2'h2);
        cr(ga(8'h07), e);
        cr(ga(8'd28), 8'h10);
        wr(ad(BOLE_OFF_DMEM, 8'h20), {24'h0, ~e});
        wr(BOLE_OFF_ADDR, 32'h20);
        run(mk(6'h0e, 5'h08), 2'h2);
        cr(ga(8'h08), ~e);
        cr(BOLE_OFF_FLAGS, ef);
        $display("load tests done");
        end_sim();
    end
endmodule : bole_core_tb
bind bole_core bole_core_sva bole_core_sva_inst (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .exec_busy,
    .flag_register);
`default_nettype wire
